// [ccet_card_cmd.v]
// What the document requires
// R01: Checksum fail: no response, no execution, flag
// R02: Illegal command: keep state, no response, flag
// R03: Illegal: unsupported class, wrong state, undefined
// R04: Finish in time or give up with error
// R05: Host read timeout for standard cards
// R06: Read access is access time plus clocks; the code counts both parts at once, so the longer part decides
// R07: Host fixed read timeout for large cards
// R08: Host write timeout for standard cards
// R09: High capacity busy at most 250ms
// R10: Extended card busy 500ms in listed cases
// R11: Block gap busy 250ms, boundary pair 500ms
// R12: Speed class mode caps busy at 250ms
// R13: Host restarts timeout at stop response
// R14: Host uses fixed write timeout above 500ms
// R15: Host erase estimate blocks times 250ms
// R16: Every command has one of four types
// R17: Broadcast with reply needs separate lines
// R18: Command line shifts leftmost bit first
// R19: Command is 48 bits with fixed markers
// R20: Checksum over 40 bits, x^7+x^3+1
// R21: Host supervisor counts against limits
//
// Purpose: Card side command receiver, checker and busy supervisor
// Assumes: Bus clock from host, sampled by the 100 MHz core clock
// Notes:   Card state machine and class tables live outside
`timescale 1ns/10ps
`include "ccet_consts.vh"

module ccet_card_cmd #(
	parameter [63:0] DEFINED_MASK = 64'h00000000000fbffd,
	parameter [63:0] BC_MASK      = 64'h0000000000000000,
	parameter [63:0] BCR_MASK     = 64'h0000000000000000,
	parameter [63:0] ADTC_MASK    = 64'h0000000000000000,
	parameter        MS_CYCLES    = `CCET_MS_NS / `CCET_CLK_NS
) (
	input  wire        clock,
	input  wire        rst,
	input  wire        bus_clk,
	input  wire        cmd_in,
	output reg         cmd_out_r,
	output reg         cmd_oe_r,
	input  wire [11:0] card_classes,
	input  wire [63:0] state_allow,
	output reg         cmd_valid_r,
	output reg  [5:0]  cmd_index_r,
	output reg  [31:0] cmd_arg_r,
	output reg  [1:0]  cmd_type_r,
	output reg         command_checksum_fail_flag,
	output reg         illegal_cmd_flag,
	output reg         timeout_err_flag,
	input  wire        status_clr,
	input  wire        resp_load,
	input  wire [47:0] resp_word,
	output reg         resp_ok_r,
	input  wire [15:0] access_time_param,
	input  wire [7:0]  access_clock_count_param,
	input  wire        read_start,
	output reg         read_due_r,
	input  wire        read_wait,
	input  wire        busy_req,
	input  wire        cap_ext,
	input  wire        busy_last,
	input  wire        boundary_span,
	input  wire        speed_class_mode,
	input  wire        stop_resp_done,
	output reg         busy_oe_r,
	output reg         give_up_r
);

	localparam RX_IDLE = 1'b0;
	localparam RX_BITS = 1'b1;
	localparam [8:0] BUSY_LIM = `CCET_BUSY_MS;
	localparam [8:0] BUSY_EXT = `CCET_BUSY_EXT_MS;
	localparam [8:0] READ_LIM = `CCET_READ_MS;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	reg  [1:0]  clk_sync_r;
	reg  [1:0]  cmd_sync_r;
	reg         clk_prev_r;
	wire        rise;
	wire        fall;

	always @(posedge clock) begin
		if (rst) begin
			clk_sync_r <= 2'h0;
			cmd_sync_r <= 2'h3;
			clk_prev_r <= 1'b0;
		end else begin
			clk_sync_r <= {clk_sync_r[0], bus_clk};
			cmd_sync_r <= {cmd_sync_r[0], cmd_in};
			clk_prev_r <= clk_sync_r[1];
		end
	end

	assign rise = clk_sync_r[1] & ~clk_prev_r;
	assign fall = ~clk_sync_r[1] & clk_prev_r;

	// ----------------------------------------------------------------
	// Command receiver
	// ----------------------------------------------------------------
	reg         rx_state_r;
	reg  [5:0]  bit_cnt_r;
	reg  [47:0] frame_r;
	reg         frame_done_r;
	wire [6:0]  crc_val;
	wire        crc_en;
	wire        crc_clr;
	wire [47:0] frame_nxt;

	assign frame_nxt = {frame_r[46:0], cmd_sync_r[1]};
	// Start bit goes in too, so all 40 covered bits feed the remainder
	assign crc_en = rise && (rx_state_r == RX_IDLE ? ~cmd_sync_r[1]
		: bit_cnt_r < 6'd39); // see R20
	assign crc_clr = rx_state_r == RX_IDLE && !(rise && ~cmd_sync_r[1]);

	ccet_seven_bit_checksum u_crc (
		.clock  (clock),
		.rst    (rst),
		.clear  (crc_clr),
		.en     (crc_en),
		.bit_in (cmd_sync_r[1]),
		.crc_r  (crc_val)
	);

	always @(posedge clock) begin
		if (rst) begin
			rx_state_r   <= RX_IDLE;
			bit_cnt_r    <= 6'h00;
			frame_r      <= 48'h000000000000;
			frame_done_r <= 1'b0;
		end else begin
			frame_done_r <= 1'b0;
			if (rise) begin
				case (rx_state_r)
				RX_IDLE: begin
					if (!cmd_sync_r[1] && !cmd_oe_r) begin
						rx_state_r <= RX_BITS;
						bit_cnt_r  <= 6'h00;
						frame_r    <= 48'h000000000000;
					end
				end
				RX_BITS: begin
					frame_r   <= frame_nxt;
					bit_cnt_r <= bit_cnt_r + 6'd1;
					if (bit_cnt_r == 6'd46) begin // see R19
						rx_state_r   <= RX_IDLE;
						frame_done_r <= 1'b1;
					end
				end
				default: rx_state_r <= RX_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks and classification
	// ----------------------------------------------------------------
	wire [5:0]  idx;
	reg         class_ok;
	wire        form_ok;
	wire        crc_ok;
	wire        illegal;
	reg  [1:0]  ctype;

	assign idx     = frame_r[`CCET_IDX_HI:`CCET_IDX_LO];
	assign form_ok = frame_r[`CCET_DIR_POS] && frame_r[`CCET_END_POS];
	assign crc_ok  = form_ok
		&& frame_r[`CCET_CRC_HI:`CCET_CRC_LO] == crc_val; // see R01

	always @* begin
		case (idx)
		6'd5:    class_ok = card_classes[9];
		6'd6:    class_ok = card_classes[10];
		6'd16:   class_ok = card_classes[2] | card_classes[4]
			| card_classes[7];
		6'd17,
		6'd18,
		6'd19:   class_ok = card_classes[2];
		default: class_ok = card_classes[0];
		endcase
	end

	// Undefined, unsupported class, or refused by present state
	assign illegal = !DEFINED_MASK[idx] || !class_ok
		|| !state_allow[idx]; // see R03

	always @* begin
		if (BC_MASK[idx]) begin
			ctype = `CCET_T_BC; // see R16
		end else if (BCR_MASK[idx]) begin
			ctype = `CCET_T_BCR;
		end else if (ADTC_MASK[idx]) begin
			ctype = `CCET_T_ADTC;
		end else begin
			ctype = `CCET_T_AC;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			cmd_valid_r <= 1'b0;
			cmd_index_r <= 6'h00;
			cmd_arg_r   <= 32'h00000000;
			cmd_type_r  <= `CCET_T_AC;
			command_checksum_fail_flag <= 1'b0;
			illegal_cmd_flag <= 1'b0;
		end else begin
			// Failing frames never pulse cmd_valid, so state stays put
			cmd_valid_r <= frame_done_r && crc_ok && !illegal; // see R01
			if (frame_done_r && crc_ok && !illegal) begin
				cmd_index_r <= idx;
				cmd_arg_r   <= frame_r[`CCET_ARG_HI:`CCET_ARG_LO];
				cmd_type_r  <= ctype;
			end
			// Set wins over a clear in the same cycle
			if (frame_done_r && !crc_ok) begin
				command_checksum_fail_flag <= 1'b1; // see R01
			end else if (status_clr) begin
				command_checksum_fail_flag <= 1'b0;
			end
			if (frame_done_r && crc_ok && illegal) begin
				illegal_cmd_flag <= 1'b1; // see R02
			end else if (status_clr) begin
				illegal_cmd_flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Response transmitter
	// ----------------------------------------------------------------
	reg  [47:0] tx_r;
	reg  [5:0]  tx_cnt_r;

	always @(posedge clock) begin
		if (rst) begin
			resp_ok_r <= 1'b0;
			tx_r      <= 48'hffffffffffff;
			tx_cnt_r  <= 6'h00;
			cmd_out_r <= 1'b1;
			cmd_oe_r  <= 1'b0;
		end else begin
			if (cmd_valid_r) begin
				resp_ok_r <= 1'b1;
			end else if (frame_done_r || resp_load) begin
				resp_ok_r <= 1'b0; // see R02
			end
			// A response is only sent after an accepted command
			if (resp_load && resp_ok_r && tx_cnt_r == 6'h00) begin
				tx_r     <= resp_word; // see R01
				tx_cnt_r <= 6'd48;
			end else if (fall && tx_cnt_r != 6'h00) begin
				cmd_oe_r  <= 1'b1;
				cmd_out_r <= tx_r[47]; // see R18
				tx_r      <= {tx_r[46:0], 1'b1};
				tx_cnt_r  <= tx_cnt_r - 6'd1;
			end else if (fall) begin
				cmd_oe_r  <= 1'b0;
				cmd_out_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read access timing
	// ----------------------------------------------------------------
	reg  [15:0] acc_cyc_r;
	reg  [7:0]  acc_clk_r;
	reg         acc_run_r;

	always @(posedge clock) begin
		if (rst) begin
			acc_cyc_r  <= 16'h0000;
			acc_clk_r  <= 8'h00;
			acc_run_r  <= 1'b0;
			read_due_r <= 1'b0;
		end else begin
			read_due_r <= 1'b0;
			if (read_start) begin
				acc_cyc_r <= access_time_param; // see R06
				acc_clk_r <= access_clock_count_param;
				acc_run_r <= 1'b1;
			end else if (acc_run_r) begin
				if (acc_cyc_r != 16'h0000) begin
					acc_cyc_r <= acc_cyc_r - 16'd1;
				end
				if (rise && acc_clk_r != 8'h00) begin
					acc_clk_r <= acc_clk_r - 8'd1;
				end
				// Both parts count down together; due once both have reached zero
				if (acc_cyc_r == 16'h0000 && acc_clk_r == 8'h00) begin
					acc_run_r  <= 1'b0;
					read_due_r <= 1'b1; // see R06
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Busy and read supervisor
	// ----------------------------------------------------------------
	reg  [31:0] ms_div_r;
	reg  [8:0]  ms_cnt_r;
	reg  [8:0]  limit;
	wire        phase;

	assign phase = busy_req | read_wait;

	always @* begin
		if (!busy_req) begin
			limit = READ_LIM;
		end else if (speed_class_mode) begin
			limit = BUSY_LIM; // see R12
		end else if (cap_ext && (busy_last || boundary_span)) begin
			limit = BUSY_EXT; // see R10 see R11
		end else begin
			limit = BUSY_LIM; // see R09 see R11
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			ms_div_r  <= 32'h00000000;
			ms_cnt_r  <= 9'h000;
			busy_oe_r <= 1'b0;
			give_up_r <= 1'b0;
			timeout_err_flag <= 1'b0;
		end else begin
			// Busy after a stop response is timed from that response
			if (!phase || stop_resp_done) begin
				ms_div_r <= 32'h00000000;
				ms_cnt_r <= 9'h000;
			end else if (ms_div_r == MS_CYCLES - 1) begin
				ms_div_r <= 32'h00000000;
				if (ms_cnt_r != limit) begin
					ms_cnt_r <= ms_cnt_r + 9'd1;
				end
			end else begin
				ms_div_r <= ms_div_r + 32'd1;
			end
			if (!phase) begin
				give_up_r <= 1'b0;
			end else if (ms_cnt_r == limit && !stop_resp_done) begin
				give_up_r <= 1'b1; // see R04
			end
			busy_oe_r <= busy_req && !give_up_r
				&& !(ms_cnt_r == limit); // see R09
			if (phase && ms_cnt_r == limit && !give_up_r) begin
				timeout_err_flag <= 1'b1; // see R04
			end else if (status_clr) begin
				timeout_err_flag <= 1'b0;
			end
		end
	end

endmodule

// [ccet_card_cmd_sva.sv]
// Purpose: Port checker for the card command block
// Assumes: MS_CYCLES matches the instance
// Notes:   Busy limits allow a few cycles of sync delay
`timescale 1ns/10ps
`include "ccet_consts.vh"

module ccet_card_cmd_sva #(
	parameter MS_CYCLES = 100000
) (
	input logic        clock,
	input logic        rst,
	input logic        cmd_out_r,
	input logic        cmd_oe_r,
	input logic [63:0] state_allow,
	input logic        cmd_valid_r,
	input logic [5:0]  cmd_index_r,
	input logic [1:0]  cmd_type_r,
	input logic        command_checksum_fail_flag,
	input logic        illegal_cmd_flag,
	input logic        timeout_err_flag,
	input logic        read_start,
	input logic        read_due_r,
	input logic [15:0] access_time_param,
	input logic [7:0]  access_clock_count_param,
	input logic        read_wait,
	input logic        busy_req,
	input logic        cap_ext,
	input logic        busy_last,
	input logic        boundary_span,
	input logic        speed_class_mode,
	input logic        stop_resp_done,
	input logic        busy_oe_r,
	input logic        give_up_r
);
	// ----------------------------------------
	// Busy length, restarted by stop response
	// ----------------------------------------
	int busy_cnt_r;
	always @(posedge clock) begin
		if (rst || !busy_oe_r || stop_resp_done)
			busy_cnt_r <= 0;
		else
			busy_cnt_r <= busy_cnt_r + 1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_CRC_QUIET: assert property ($rose(command_checksum_fail_flag)
		|-> !cmd_valid_r ##1 !cmd_valid_r) else $error("bad frame accepted");
	AST_ILL_QUIET: assert property ($rose(illegal_cmd_flag)
		|-> !cmd_valid_r ##1 !cmd_valid_r) else $error("illegal accepted");
	AST_LEGAL_STATE: assert property (cmd_valid_r
		|-> state_allow[cmd_index_r]) else $error("state not allowed");
	AST_TYPE_AC: assert property (cmd_valid_r
		|-> cmd_type_r == `CCET_T_AC) else $error("wrong type");
	AST_VALID_PULSE: assert property (cmd_valid_r |=> !cmd_valid_r)
		else $error("accept not one cycle");
	AST_LINE_IDLE: assert property (!cmd_oe_r |-> cmd_out_r)
		else $error("line not idle high");
	AST_BUSY_FOLLOW: assert property ($rose(busy_req) && !give_up_r
		&& !read_wait |=> busy_oe_r) else $error("busy not shown");
	AST_GIVE_UP: assert property ($rose(give_up_r)
		|-> timeout_err_flag && !busy_oe_r) else $error("give up w/o error");
	AST_BUSY_250: assert property (busy_oe_r && (!cap_ext
		|| speed_class_mode || !(busy_last || boundary_span))
		|-> busy_cnt_r <= 250 * MS_CYCLES + 3) else $error("busy over 250");
	AST_READ_DUE: assert property (read_start && access_time_param == 0
		&& access_clock_count_param == 0 |=> !read_due_r ##1 read_due_r)
		else $error("read due late");
endmodule

bind ccet_card_cmd ccet_card_cmd_sva #(.MS_CYCLES(MS_CYCLES)) chk_u (.*);

// [ccet_consts.vh]
// Purpose: Shared constants of the card command error and timeout block
// Assumes: 100 MHz core clock
// Notes:   Times in their own units, cycle counts derived in the modules
`ifndef CCET_CONSTS_VH
`define CCET_CONSTS_VH

// ----------------------------------------------------------------
// Command frame layout
// ----------------------------------------------------------------
`define CCET_FRAME_BITS   48
`define CCET_CRC_BITS     40
`define CCET_START_POS    47
`define CCET_DIR_POS      46
`define CCET_IDX_HI       45
`define CCET_IDX_LO       40
`define CCET_ARG_HI       39
`define CCET_ARG_LO       8
`define CCET_CRC_HI       7
`define CCET_CRC_LO       1
`define CCET_END_POS      0
`define CCET_CRC_RESET    7'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCET_CLK_NS       10
`define CCET_MS_NS        1000000
`define CCET_BUSY_MS      250
`define CCET_BUSY_EXT_MS  500
`define CCET_READ_MS      100

// ----------------------------------------------------------------
// Command types
// ----------------------------------------------------------------
`define CCET_T_BC         2'h0
`define CCET_T_BCR        2'h1
`define CCET_T_AC         2'h2
`define CCET_T_ADTC       2'h3

`endif

// [ccet_host_model.sv]
// Purpose: Host model driving bus clock and command line
// Assumes: One card on its own command line, pull-up idle high
// Notes:   Bus clock stands still between transfers
`timescale 1ns/10ps

module ccet_host_model (
	output reg  bus_clk,
	output reg  host_drv,
	input  wire card_oe,
	input  wire cmd_line
);
	initial begin
		bus_clk = 1'b0;
		host_drv = 1'b1;
	end
	// ----------------------------------------
	// Frame building and shifting
	// ----------------------------------------
	function [6:0] seven_bit_checksum(input [39:0] d);
		integer i;
		begin
			seven_bit_checksum = 7'h00;
			for (i = 39; i >= 0; i = i - 1)
				seven_bit_checksum = {seven_bit_checksum[5:0], 1'b0} ^ ((d[i] ^ seven_bit_checksum[6]) ? 7'h09 : 7'h00);
		end
	endfunction
	task tick(input b);
		begin
			host_drv = b;
			#62.5 bus_clk = 1'b1;
			#62.5 bus_clk = 1'b0;
		end
	endtask
	// Single card only, so reply commands are safe here
	task send(input [5:0] idx, input [31:0] arg, input bad);
		reg [47:0] f;
		integer    i;
		begin
			f[47:8] = {2'b01, idx, arg};
			f[7:0] = {seven_bit_checksum(f[47:8]) ^ {6'h00, bad}, 1'b1};
			for (i = 47; i >= 0; i = i - 1)
				tick(f[i]);
			repeat (8) tick(1'b1);
		end
	endtask
	task capture(output [47:0] w);
		integer i;
		begin
			w = 48'h0;
			for (i = 0; i < 60; i = i + 1) begin
				#62.5 bus_clk = 1'b1;
				if (card_oe)
					w = {w[46:0], cmd_line};
				#62.5 bus_clk = 1'b0;
			end
		end
	endtask
endmodule

// [ccet_seven_bit_checksum.v]
// Purpose: Serial seven_bit_checksum generator, x^7 + x^3 + 1
// Assumes: One bit per enable, leftmost bit first
// Notes:   Clear restarts the remainder for a new frame
`timescale 1ns/10ps
`include "ccet_consts.vh"

module ccet_seven_bit_checksum (
	input  wire       clock,
	input  wire       rst,
	input  wire       clear,
	input  wire       en,
	input  wire       bit_in,
	output reg  [6:0] crc_r
);

	wire fb;

	assign fb = bit_in ^ crc_r[6];

	// ----------------------------------------------------------------
	// Shift register
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		if (rst || clear) begin
			crc_r <= `CCET_CRC_RESET;
		end else if (en) begin
			crc_r <= {crc_r[5:3], crc_r[2] ^ fb, crc_r[1:0], fb}; // see R20
		end
	end

endmodule

// [tb_top.sv]
// Purpose: Testbench for the card command block
// Assumes: Short millisecond count for run time
// Notes:   Limits checked with a small sync margin
`timescale 1ns/10ps
`include "ccet_consts.vh"

module tb_top;
	localparam MS = 20;
	reg         clock = 0, rst = 1, seen_v = 0;
	reg  [11:0] card_classes = 12'hfff;
	reg  [63:0] state_allow = {64{1'b1}};
	reg         status_clr = 0, resp_load = 0, read_start = 0, read_wait = 0;
	reg         busy_req = 0, cap_ext = 0, busy_last = 0, boundary_span = 0;
	reg         speed_class_mode = 0, stop_resp_done = 0;
	reg  [47:0] resp_word = 48'h3c12345678a5, cap;
	reg  [15:0] access_time_param = 0;
	reg  [7:0]  access_clock_count_param = 0;
	wire        bus_clk, host_drv, cmd_out_r, cmd_oe_r, cmd_valid_r;
	wire        command_checksum_fail_flag, illegal_cmd_flag, resp_ok_r;
	wire        timeout_err_flag, read_due_r, busy_oe_r, give_up_r;
	wire [5:0]  cmd_index_r;
	wire [31:0] cmd_arg_r;
	wire [1:0]  cmd_type_r;
	wire        cmd_in = cmd_oe_r ? cmd_out_r : host_drv;
	integer     failures = 0, n_tests = 0, n;

	ccet_card_cmd #(.MS_CYCLES(MS)) dut_u (.*);
	ccet_host_model host_u (.bus_clk(bus_clk), .host_drv(host_drv),
		.card_oe(cmd_oe_r), .cmd_line(cmd_in));

	always #5 clock = ~clock;
	always @(posedge clock) if (cmd_valid_r) seen_v <= 1'b1;

	// ----------------------------------------
	// Checking and access tasks
	// ----------------------------------------
	task chk(input [63:0] seen, input [63:0] exp, input [95:0] what);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
			end
		end
	endtask
	task finish_test;
		begin
			if (failures == 0 && n_tests > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task hang;
		begin
			failures = failures + 1;
			finish_test;
		end
	endtask
	task clr;
		begin
			@(negedge clock) status_clr = 1;
			@(negedge clock) status_clr = 0;
		end
	endtask
	// Result bits: accepted, illegal flag, checksum flag
	task cmd(input [5:0] idx, input bad, input [2:0] exp);
		begin
			seen_v = 0;
			host_u.send(idx, 32'h5, bad);
			chk({seen_v, illegal_cmd_flag, command_checksum_fail_flag}, exp,
				"result");
			clr;
		end
	endtask
	// Mode bits: read, ext, last, boundary, speed class
	task phase(input [4:0] m, input stp, input integer ms);
		begin
			@(negedge clock);
			{read_wait, cap_ext, busy_last, boundary_span, speed_class_mode} = m;
			busy_req = !m[4];
			n = 0;
			while (!give_up_r && n < 12000) begin
				@(negedge clock);
				n = n + 1;
				stop_resp_done = stp && n == 200 * MS;
			end
			if (n == 12000)
				hang;
			chk(n >= ms * MS && n <= ms * MS + 6, 1, "limit");
			chk({busy_oe_r, timeout_err_flag}, 2'b01, "give up");
			{read_wait, busy_req} = 2'b00;
			clr;
		end
	endtask

	initial begin
		repeat (10) @(negedge clock);
		rst = 0;
		chk({cmd_oe_r, cmd_out_r, cmd_type_r}, 4'h6, "reset");
		repeat (5) @(negedge clock);
		seen_v = 0;
		host_u.send(6'd17, 32'h89abcdef, 1'b0);
		chk({seen_v, cmd_index_r, cmd_arg_r}, {1'b1, 6'd17, 32'h89abcdef},
			"fields");
		chk({resp_ok_r, cmd_type_r}, {1'b1, `CCET_T_AC}, "type");
		@(negedge clock) resp_load = 1;
		@(negedge clock) resp_load = 0;
		host_u.capture(cap);
		chk(cap, resp_word, "response");
		cmd(6'd17, 1'b1, 3'b001);
		cmd(6'd14, 1'b0, 3'b010);
		card_classes[2] = 0;
		cmd(6'd17, 1'b0, 3'b010);
		card_classes[2] = 1;
		state_allow[17] = 0;
		cmd(6'd17, 1'b0, 3'b010);
		state_allow[17] = 1;
		chk(cmd_arg_r, 32'h89abcdef, "kept arg");
		@(negedge clock) read_start = 1;
		@(negedge clock) read_start = 0;
		access_time_param = 16'd20;
		@(negedge clock) read_start = 1;
		@(negedge clock) read_start = 0;
		n = 1;
		while (!read_due_r && n < 100) begin
			@(negedge clock);
			n = n + 1;
		end
		if (n == 100)
			hang;
		chk(n, 22, "access");
		phase(5'b10000, 0, 100);
		phase(5'b00000, 0, 250);
		phase(5'b01100, 0, 500);
		phase(5'b01010, 0, 500);
		phase(5'b01101, 0, 250);
		phase(5'b00000, 1, 450);
		finish_test;
	end
endmodule
